// ### mcu_exec_unit.sv
// Purpose: executes one instruction per command write, reached over APB
// Assumes: single pclk domain, APB master waits on pready
// Notes:   one instruction cycle is four pclk cycles of busy time
module mcu_exec_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             halted,
  output logic             global_irq_enable
);

  typedef struct packed {
    logic [mcu_exec_pkg::MEM_DEPTH-1:0][7:0]     mem;
    logic [mcu_exec_pkg::STACK_DEPTH-1:0][15:0]  stack;
    logic [mcu_exec_pkg::SP_W-1:0]               sp;
    logic [7:0]                                  acc;
    mcu_exec_pkg::flags_t                        fl;
    logic [15:0]                                 pc;
    logic [mcu_exec_pkg::IDX_W-1:0]              midx;
    logic                                        halted;
    logic                                        wdt_en;
    logic                                        pready;
    logic                                        pslverr;
    logic [31:0]                                 prdata;
  } core_st_t;

  core_st_t st_r;
  core_st_t st_nxt;

  logic                                  busy;
  logic                                  tmr_start;
  logic [mcu_exec_pkg::TMR_W-1:0]        tmr_load;
  logic                                  wdt_clr;
  logic                                  wdt_ovf;
  logic [mcu_exec_pkg::WDT_CNT_W-1:0]    wdt_count;

  icycle_timer #(
    .W (mcu_exec_pkg::TMR_W)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tmr_start),
    .load    (tmr_load),
    .busy    (busy)
  );

  wdt_counter #(
    .PW (mcu_exec_pkg::WDT_PRESC_W),
    .CW (mcu_exec_pkg::WDT_CNT_W)
  ) u_wdt (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (st_r.wdt_en),
    .clr     (wdt_clr),
    .ovf     (wdt_ovf),
    .count   (wdt_count)
  );

  always_comb begin
    logic                           setup;
    logic                           commit;
    logic                           mapped;
    logic                           go;
    mcu_exec_pkg::op_t              op;
    logic [mcu_exec_pkg::IDX_W-1:0] idx;
    logic [15:0]                    operand;
    logic [7:0]                     lit;
    logic [7:0]                     m;
    logic [7:0]                     a;
    logic [7:0]                     val;
    logic                           to_mem;
    logic                           to_acc;
    logic                           set_z;
    logic                           skip;
    logic [1:0]                     icyc;
    logic [4:0]                     lo;
    logic [4:0]                     hi;
    logic                           ac1;
    logic [8:0]                     sum;
    logic [4:0]                     nsum;
    logic [mcu_exec_pkg::SP_W-1:0]  sp_dn;
    logic [31:0]                    rd;
    setup     = 1'b0;
    commit    = 1'b0;
    mapped    = 1'b0;
    go        = 1'b0;
    op        = mcu_exec_pkg::op_t'(pwdata[mcu_exec_pkg::CMD_OP_LSB +: 5]);
    idx       = pwdata[mcu_exec_pkg::CMD_IDX_LSB +: mcu_exec_pkg::IDX_W];
    operand   = pwdata[15:0];
    lit       = pwdata[7:0];
    m         = st_r.mem[idx];
    a         = st_r.acc;
    val       = 8'h00;
    to_mem    = 1'b0;
    to_acc    = 1'b0;
    set_z     = 1'b0;
    skip      = 1'b0;
    icyc      = 2'd1;
    lo        = 5'h00;
    hi        = 5'h00;
    ac1       = 1'b0;
    sum       = 9'h000;
    nsum      = 5'h00;
    sp_dn     = st_r.sp - mcu_exec_pkg::SP_W'(1);
    rd        = 32'h0000_0000;
    tmr_start = 1'b0;
    tmr_load  = '0;
    wdt_clr   = 1'b0;
    st_nxt    = st_r;

    // one wait state: pready and read data come from flops
    setup  = psel && penable && !st_r.pready;
    commit = psel && penable && st_r.pready;

    unique case (paddr)
      mcu_exec_pkg::OFS_CMD: begin
        mapped = 1'b1;
      end
      mcu_exec_pkg::OFS_ACC: begin
        mapped = 1'b1;
        rd     = {24'h000000, st_r.acc};
      end
      mcu_exec_pkg::OFS_STATUS: begin
        mapped = 1'b1;
        rd     = {25'h0000000, st_r.fl};
        rd[mcu_exec_pkg::STAT_BUSY]   = busy;
        rd[mcu_exec_pkg::STAT_HALTED] = st_r.halted;
      end
      mcu_exec_pkg::OFS_PC: begin
        mapped = 1'b1;
        rd     = {16'h0000, st_r.pc};
      end
      mcu_exec_pkg::OFS_MIDX: begin
        mapped = 1'b1;
        rd     = {28'h0000000, st_r.midx};
      end
      mcu_exec_pkg::OFS_MDATA: begin
        mapped = 1'b1;
        rd     = {24'h000000, st_r.mem[st_r.midx]};
      end
      mcu_exec_pkg::OFS_CTRL: begin
        mapped = 1'b1;
        rd[mcu_exec_pkg::CTRL_WDT_EN] = st_r.wdt_en;
      end
      mcu_exec_pkg::OFS_STACK: begin
        mapped = 1'b1;
        rd     = {29'h00000000, st_r.sp};
      end
      mcu_exec_pkg::OFS_WDT: begin
        mapped = 1'b1;
        rd     = {24'h000000, wdt_count};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase

    // a command while busy or powered down is refused with pslverr
    go = pwrite && (paddr == mcu_exec_pkg::OFS_CMD) && !busy && !st_r.halted;

    st_nxt.pready = setup;
    if (setup) begin
      st_nxt.prdata  = pwrite ? 32'h0000_0000 : rd;
      st_nxt.pslverr = !mapped ||
                       (pwrite && (paddr == mcu_exec_pkg::OFS_CMD) && !go);
    end else begin
      st_nxt.prdata  = 32'h0000_0000;
      st_nxt.pslverr = 1'b0;
    end

    // execute only what setup accepted, so pslverr and effect always agree
    if (commit && pwrite && (paddr == mcu_exec_pkg::OFS_CMD) && !st_r.pslverr) begin
      st_nxt.pc = st_r.pc + 16'h0001;
      unique case (op)
        mcu_exec_pkg::OP_NOP: begin
        end
        mcu_exec_pkg::OP_INVERT_TO_ACC: begin
          val    = ~m;
          to_acc = 1'b1;
          set_z  = 1'b1;
        end
        mcu_exec_pkg::OP_BCD_FIXUP: begin
          lo = {1'b0, a[3:0]};
          if (a[3:0] > mcu_exec_pkg::BCD_MAX || st_r.fl.ac) begin
            lo  = lo + mcu_exec_pkg::BCD_FIX;
            ac1 = lo[4];
          end
          hi = {1'b0, a[7:4]} + {4'h0, ac1};
          if (hi > {1'b0, mcu_exec_pkg::BCD_MAX} || st_r.fl.c) begin
            hi          = hi + mcu_exec_pkg::BCD_FIX;
            st_nxt.fl.c = 1'b1;
          end
          val    = {hi[3:0], lo[3:0]};
          to_mem = 1'b1;
        end
        mcu_exec_pkg::OP_COUNT_UP, mcu_exec_pkg::OP_COUNT_UP_TO_ACC: begin
          val    = m + 8'h01;
          to_mem = (op == mcu_exec_pkg::OP_COUNT_UP);
          to_acc = !to_mem;
          set_z  = 1'b1;
        end
        mcu_exec_pkg::OP_COUNT_DOWN, mcu_exec_pkg::OP_COUNT_DOWN_TO_ACC: begin
          val    = m - 8'h01;
          to_mem = (op == mcu_exec_pkg::OP_COUNT_DOWN);
          to_acc = !to_mem;
          set_z  = 1'b1;
        end
        mcu_exec_pkg::OP_POWER_DOWN: begin
          wdt_clr          = 1'b1;
          st_nxt.fl.pd     = 1'b1;
          st_nxt.fl.wdt_to = 1'b0;
          st_nxt.halted    = 1'b1;
        end
        mcu_exec_pkg::OP_COPY_ACC_TO_MEM: begin
          val    = a;
          to_mem = 1'b1;
        end
        mcu_exec_pkg::OP_COPY_MEM_TO_ACC: begin
          val    = m;
          to_acc = 1'b1;
        end
        mcu_exec_pkg::OP_COPY_LIT_TO_ACC: begin
          val    = lit;
          to_acc = 1'b1;
        end
        mcu_exec_pkg::OP_OR_MEM, mcu_exec_pkg::OP_BITWISE_OR_TO_MEMORY: begin
          val    = a | m;
          to_mem = (op == mcu_exec_pkg::OP_BITWISE_OR_TO_MEMORY);
          to_acc = !to_mem;
          set_z  = 1'b1;
        end
        mcu_exec_pkg::OP_OR_LIT: begin
          val    = a | lit;
          to_acc = 1'b1;
          set_z  = 1'b1;
        end
        mcu_exec_pkg::OP_SUBROUTINE_EXIT, mcu_exec_pkg::OP_SUBROUTINE_EXIT_LIT,
        mcu_exec_pkg::OP_INTERRUPT_EXIT: begin
          st_nxt.pc = st_r.stack[sp_dn];
          st_nxt.sp = sp_dn;
          icyc      = 2'd2;
          if (op == mcu_exec_pkg::OP_SUBROUTINE_EXIT_LIT) begin
            val    = lit;
            to_acc = 1'b1;
          end
          if (op == mcu_exec_pkg::OP_INTERRUPT_EXIT) begin
            st_nxt.fl.irq_en = 1'b1;
          end
        end
        mcu_exec_pkg::OP_ROTATE_LEFT_MEMORY, mcu_exec_pkg::OP_ROTATE_LEFT_TO_ACC: begin
          val    = {m[6:0], m[7]};
          to_mem = (op == mcu_exec_pkg::OP_ROTATE_LEFT_MEMORY);
          to_acc = !to_mem;
        end
        mcu_exec_pkg::OP_ROTATE_LEFT_VIA_CARRY,
        mcu_exec_pkg::OP_ROTATE_LEFT_VIA_CARRY_TO_ACC: begin
          val         = {m[6:0], st_r.fl.c};
          st_nxt.fl.c = m[7];
          to_mem      = (op == mcu_exec_pkg::OP_ROTATE_LEFT_VIA_CARRY);
          to_acc      = !to_mem;
        end
        mcu_exec_pkg::OP_ROTATE_RIGHT_MEMORY, mcu_exec_pkg::OP_ROTATE_RIGHT_TO_ACC: begin
          val    = {m[0], m[7:1]};
          to_mem = (op == mcu_exec_pkg::OP_ROTATE_RIGHT_MEMORY);
          to_acc = !to_mem;
        end
        mcu_exec_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
        mcu_exec_pkg::OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC: begin
          val         = {st_r.fl.c, m[7:1]};
          st_nxt.fl.c = m[0];
          to_mem      = (op == mcu_exec_pkg::OP_ROTATE_RIGHT_VIA_CARRY);
          to_acc      = !to_mem;
        end
        mcu_exec_pkg::OP_COUNT_DOWN_SKIP_ZERO,
        mcu_exec_pkg::OP_COUNT_DOWN_SKIP_ZERO_TO_ACC: begin
          val    = m - 8'h01;
          to_mem = (op == mcu_exec_pkg::OP_COUNT_DOWN_SKIP_ZERO);
          to_acc = !to_mem;
          skip   = (val == 8'h00);
        end
        mcu_exec_pkg::OP_SET_MEMORY: begin
          val    = mcu_exec_pkg::ALL_ONES;
          to_mem = 1'b1;
        end
        mcu_exec_pkg::OP_SUBTRACT_WITH_BORROW,
        mcu_exec_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
          sum          = {1'b0, a} + {1'b0, ~m} + {8'h00, st_r.fl.c};
          nsum         = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, st_r.fl.c};
          val          = sum[7:0];
          st_nxt.fl.c  = sum[8];
          st_nxt.fl.ac = nsum[4];
          st_nxt.fl.ov = (a[7] == ~m[7]) && (sum[7] != a[7]);
          set_z        = 1'b1;
          to_mem       = (op == mcu_exec_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM);
          to_acc       = !to_mem;
        end
        mcu_exec_pkg::OP_JUMP_DIRECT: begin
          st_nxt.pc = operand;
          icyc      = 2'd2;
        end
        default: begin
        end
      endcase
      // a skip drops the prefetched word: pc steps over it, dummy cycle added
      if (skip) begin
        st_nxt.pc = st_r.pc + 16'h0002;
        icyc      = 2'd2;
      end
      if (to_mem) begin
        st_nxt.mem[idx] = val;
      end
      if (to_acc) begin
        st_nxt.acc = val;
      end
      if (set_z) begin
        st_nxt.fl.z = (val == 8'h00);
      end
      tmr_start = 1'b1;
      tmr_load  = mcu_exec_pkg::TMR_W'(icyc * mcu_exec_pkg::CLKS_PER_ICYCLE);
    end else if (commit && pwrite) begin
      unique case (paddr)
        mcu_exec_pkg::OFS_ACC: begin
          st_nxt.acc = pwdata[7:0];
        end
        mcu_exec_pkg::OFS_STATUS: begin
          st_nxt.fl.c      = pwdata[0];
          st_nxt.fl.ac     = pwdata[1];
          st_nxt.fl.z      = pwdata[2];
          st_nxt.fl.ov     = pwdata[3];
          st_nxt.fl.irq_en = pwdata[6];
        end
        mcu_exec_pkg::OFS_PC: begin
          st_nxt.pc = pwdata[15:0];
        end
        mcu_exec_pkg::OFS_MIDX: begin
          st_nxt.midx = pwdata[mcu_exec_pkg::IDX_W-1:0];
        end
        mcu_exec_pkg::OFS_MDATA: begin
          st_nxt.mem[st_r.midx] = pwdata[7:0];
        end
        mcu_exec_pkg::OFS_CTRL: begin
          st_nxt.wdt_en = pwdata[mcu_exec_pkg::CTRL_WDT_EN];
          if (pwdata[mcu_exec_pkg::CTRL_WAKE]) begin
            st_nxt.halted = 1'b0;
          end
        end
        mcu_exec_pkg::OFS_STACK: begin
          st_nxt.stack[st_r.sp] = pwdata[15:0];
          st_nxt.sp             = st_r.sp + mcu_exec_pkg::SP_W'(1);
        end
        default: begin
        end
      endcase
    end

    // timeout sets last so it wins over any clear in the same cycle
    if (wdt_ovf) begin
      st_nxt.fl.wdt_to = 1'b1;
      st_nxt.halted    = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= '0;
      st_r.acc    <= mcu_exec_pkg::ACC_RST;
      st_r.pc     <= mcu_exec_pkg::PC_RST;
      st_r.fl     <= mcu_exec_pkg::FLAGS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata            = st_r.prdata;
  assign pready            = st_r.pready;
  assign pslverr           = st_r.pslverr;
  assign halted            = st_r.halted;
  assign global_irq_enable = st_r.fl.irq_en;

endmodule

// ### mcu_exec_pkg.sv
// Purpose: shared constants and types for the instruction execution unit
// Assumes: APB byte addresses, 32-bit data, 100 MHz pclk
// Notes:   opcode codes follow the order of op_t, starting at 0
package mcu_exec_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CLKS_PER_ICYCLE = 4;
  localparam int unsigned TMR_W           = 4;
  localparam int unsigned WDT_PRESC_W     = 8;
  localparam int unsigned WDT_CNT_W       = 8;
  localparam int unsigned MEM_DEPTH       = 16;
  localparam int unsigned IDX_W           = 4;
  localparam int unsigned STACK_DEPTH     = 8;
  localparam int unsigned SP_W            = 3;

  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0C;
  localparam logic [7:0] OFS_MIDX   = 8'h10;
  localparam logic [7:0] OFS_MDATA  = 8'h14;
  localparam logic [7:0] OFS_CTRL   = 8'h18;
  localparam logic [7:0] OFS_STACK  = 8'h1C;
  localparam logic [7:0] OFS_WDT    = 8'h20;

  localparam int unsigned CMD_OP_LSB   = 24;
  localparam int unsigned CMD_IDX_LSB  = 16;
  localparam int unsigned STAT_BUSY    = 8;
  localparam int unsigned STAT_HALTED  = 9;
  localparam int unsigned CTRL_WAKE    = 0;
  localparam int unsigned CTRL_WDT_EN  = 1;

  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [7:0]  ALL_ONES = 8'hFF;
  localparam logic [3:0]  BCD_MAX  = 4'h9;
  localparam logic [4:0]  BCD_FIX  = 5'h06;

  // bit order gives c at bit 0 up to the global enable at bit 6
  typedef struct packed {
    logic irq_en;
    logic wdt_to;
    logic pd;
    logic ov;
    logic z;
    logic ac;
    logic c;
  } flags_t;

  localparam flags_t FLAGS_RST = '0;

  typedef enum logic [4:0] {
    OP_NOP, OP_INVERT_TO_ACC, OP_BCD_FIXUP, OP_COUNT_UP, OP_COUNT_UP_TO_ACC,
    OP_COUNT_DOWN, OP_COUNT_DOWN_TO_ACC, OP_POWER_DOWN, OP_COPY_ACC_TO_MEM,
    OP_COPY_MEM_TO_ACC, OP_COPY_LIT_TO_ACC, OP_OR_MEM, OP_OR_LIT,
    OP_BITWISE_OR_TO_MEMORY, OP_SUBROUTINE_EXIT, OP_SUBROUTINE_EXIT_LIT,
    OP_INTERRUPT_EXIT, OP_ROTATE_LEFT_MEMORY, OP_ROTATE_LEFT_TO_ACC,
    OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_LEFT_VIA_CARRY_TO_ACC,
    OP_ROTATE_RIGHT_MEMORY, OP_ROTATE_RIGHT_TO_ACC, OP_ROTATE_RIGHT_VIA_CARRY,
    OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC, OP_COUNT_DOWN_SKIP_ZERO,
    OP_COUNT_DOWN_SKIP_ZERO_TO_ACC, OP_SET_MEMORY, OP_SUBTRACT_WITH_BORROW,
    OP_SUBTRACT_WITH_BORROW_TO_MEM, OP_JUMP_DIRECT
  } op_t;

endpackage

// ### icycle_timer.sv
// Purpose: holds the core busy for a loaded number of clocks
// Assumes: start only while not busy
// Notes:   busy is high from the edge after start for load clocks
module icycle_timer #(
  parameter int unsigned W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              busy
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_st_t;

  tmr_st_t st_r;
  tmr_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.cnt = load;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = (st_r.cnt != '0);

endmodule

// ### wdt_counter.sv
// Purpose: watchdog prescaler and counter with synchronous clear
// Assumes: clr and en come from the pclk domain
// Notes:   ovf is a one-cycle pulse when both stages wrap
module wdt_counter #(
  parameter int unsigned PW = 8,
  parameter int unsigned CW = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          en,
  input  wire logic          clr,
  output logic               ovf,
  output logic [CW-1:0]      count
);

  typedef struct packed {
    logic [PW-1:0] presc;
    logic [CW-1:0] cnt;
    logic          ovf;
  } wdt_st_t;

  wdt_st_t st_r;
  wdt_st_t st_nxt;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ovf = 1'b0;
    if (clr) begin
      st_nxt = '0;
    end else if (en) begin
      st_nxt.presc = st_r.presc + PW'(1);
      if (&st_r.presc) begin
        st_nxt.cnt = st_r.cnt + CW'(1);
        st_nxt.ovf = &st_r.cnt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ovf   = st_r.ovf;
  assign count = st_r.cnt;

endmodule

// ### mcu_exec_chk.sv
// Purpose: port-level checks of bus timing, halt and interrupt enable
// Assumes: one wait state per transfer as handed over
// Notes:   register contents are judged by the bench, not here
module mcu_exec_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        halted,
  input wire logic        global_irq_enable
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic done;
  logic cmd;
  assign done = psel && penable && pready && pwrite;
  assign cmd  = done && paddr == mcu_exec_pkg::OFS_CMD && !pslverr;
  wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("answer not after one wait");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == '0) else $error("read data leaks");
  irq_set_a: assert property (cmd && pwdata[28:24] == 5'h10 |=> global_irq_enable)
    else $error("irq enable not set");
  irq_cause_a: assert property ($rose(global_irq_enable) |-> $past(done))
    else $error("irq enable rose alone");
  halt_entry_a: assert property (cmd && pwdata[28:24] == 5'h07 |=> halted)
    else $error("no halt");
  halt_cause_a: assert property ($rose(halted) |-> $past(cmd && pwdata[28:24] == 5'h07))
    else $error("halt without command");
  halt_refuse_a: assert property (halted && $past(halted) && done
    && paddr == mcu_exec_pkg::OFS_CMD |-> pslverr) else $error("halted core ran");
  cover property (cmd && pwdata[28:24] == 5'h07);
  cover property ($rose(global_irq_enable));
  cover property (pslverr);
endmodule
bind mcu_exec_unit mcu_exec_chk mcu_exec_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .halted(halted), .global_irq_enable(global_irq_enable));

// ### mcu_exec_unit_tb.sv
// Purpose: random and corner checks of every opcode over APB
// Assumes: pready sampled at the rising edge that completes the transfer
// Notes:   watchdog overflow not run, a full period is 65536 clocks
module mcu_exec_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic [7:0] m; logic [6:0] f; logic [15:0] pc;} exp_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, halted, global_irq_enable;
  int          err_total = 0, comparisons = 0;
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
  mcu_exec_unit mcu_exec_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halted(halted), .global_irq_enable(global_irq_enable));
  always #5 pclk = ~pclk;
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [31:0] c);
    int n;
    n = 0;
    apb(1, mcu_exec_pkg::OFS_CMD, c);
    do begin
      apb(0, mcu_exec_pkg::OFS_STATUS, '0);
      n++;
    end while (rd[mcu_exec_pkg::STAT_BUSY] !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  function automatic exp_t model(input logic [4:0] op, input exp_t s, input logic [15:0] opd, top);
    logic [8:0] t;
    logic [4:0] lo;
    logic [7:0] r;
    logic       c;
    c = s.f[0];
    s.pc = s.pc + 16'h0001;
    r = s.m - 8'h01;
    case (op)
      1: s.a = ~s.m;
      2: begin
        lo = (s.a[3:0] > 4'h9 || s.f[1]) ? s.a[3:0] + 5'h06 : {1'b0, s.a[3:0]};
        t = {5'h00, s.a[7:4]} + lo[4];
        if (t > 9'h009 || c) begin
          t = t + 9'h006;
          c = 1'b1;
        end
        s.m = {t[3:0], lo[3:0]};
      end
      3: s.m = s.m + 8'h01;
      4: s.a = s.m + 8'h01;
      5, 25: s.m = r;
      6, 26: s.a = r;
      8: s.m = s.a;
      9: s.a = s.m;
      10, 15: s.a = opd[7:0];
      11: s.a = s.a | s.m;
      12: s.a = s.a | opd[7:0];
      13: s.m = s.a | s.m;
      17: s.m = {s.m[6:0], s.m[7]};
      18: s.a = {s.m[6:0], s.m[7]};
      21: s.m = {s.m[0], s.m[7:1]};
      22: s.a = {s.m[0], s.m[7:1]};
      27: s.m = mcu_exec_pkg::ALL_ONES;
      30: s.pc = opd;
      default: ;
    endcase
    if (op inside {19, 20}) {c, r} = {s.m, c};
    if (op inside {23, 24}) {r, c} = {c, s.m};
    if (op inside {19, 23}) s.m = r;
    if (op inside {20, 24}) s.a = r;
    if (op inside {14, 15, 16}) s.pc = top;
    if (op == 16) s.f[6] = 1'b1;
    if (op inside {25, 26} && r == 8'h00) s.pc = s.pc + 16'h0001;
    if (op inside {28, 29}) begin
      t = s.a + {1'b0, ~s.m} + c;
      lo = s.a[3:0] + {1'b0, ~s.m[3:0]} + c;
      s.f[3] = (s.a[7] != s.m[7]) && (t[7] != s.a[7]);
      s.f[1] = lo[4];
      c = t[8];
      s.f[2] = t[7:0] == 8'h00;
      if (op == 28) s.a = t[7:0];
      else s.m = t[7:0];
    end
    if (op inside {1, 4, 6, 11, 12}) s.f[2] = s.a == 8'h00;
    if (op inside {3, 5, 13}) s.f[2] = s.m == 8'h00;
    if (op inside {2, 19, 20, 23, 24, 28, 29}) s.f[0] = c;
    return s;
  endfunction
  initial begin
    exp_t        s, e;
    logic [15:0] top, opd;
    logic [3:0]  ix;
    void'($urandom(32'h5289325C));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, mcu_exec_pkg::OFS_STATUS, '0);
    `CHK("status_rst", 32'h00000000, rd)
    for (int i = 0; i < 64; i++) begin
      s = {8'($urandom), 8'($urandom), 7'($urandom) & 7'h4F, 16'($urandom)};
      if (i[5]) s.m = 8'h01; // corner: count to zero, skip taken
      {top, opd, ix} = 36'($urandom) << 4 ^ 36'($urandom);
      if (i % 32 == 7) continue;
      apb(1, mcu_exec_pkg::OFS_MIDX, 32'(ix));
      apb(1, mcu_exec_pkg::OFS_MDATA, 32'(s.m));
      apb(1, mcu_exec_pkg::OFS_ACC, 32'(s.a));
      apb(1, mcu_exec_pkg::OFS_STATUS, 32'(s.f));
      apb(1, mcu_exec_pkg::OFS_PC, 32'(s.pc));
      apb(1, mcu_exec_pkg::OFS_STACK, 32'(top));
      run(32'(i % 32) << mcu_exec_pkg::CMD_OP_LSB | 32'(ix) << mcu_exec_pkg::CMD_IDX_LSB | 32'(opd));
      e = model(5'(i), s, opd, top);
      `CHK("flags", e.f, rd[6:0])
      apb(0, mcu_exec_pkg::OFS_ACC, '0);
      `CHK("acc", e.a, rd[7:0])
      apb(0, mcu_exec_pkg::OFS_MDATA, '0);
      `CHK("mem", e.m, rd[7:0])
      apb(0, mcu_exec_pkg::OFS_PC, '0);
      `CHK("pc", e.pc, rd[15:0])
    end
    apb(1, mcu_exec_pkg::OFS_CTRL, 32'h00000002);
    repeat (600) @(posedge pclk);
    apb(0, mcu_exec_pkg::OFS_WDT, '0);
    `CHK("wdt_run", 1'b1, rd[7:0] != 8'h00)
    apb(1, mcu_exec_pkg::OFS_PC, 32'h00001234);
    run(32'h07000000);
    `CHK("halted", 1'b1, halted)
    `CHK("pd_to", 2'b01, rd[5:4])
    apb(0, mcu_exec_pkg::OFS_PC, '0);
    `CHK("pc_halt", 32'h00001235, rd)
    apb(0, mcu_exec_pkg::OFS_WDT, '0);
    `CHK("wdt_clr", 32'h00000000, rd)
    apb(1, mcu_exec_pkg::OFS_CMD, 32'h1E000000);
    `CHK("halt_refuse", 1'b1, er)
    apb(1, mcu_exec_pkg::OFS_CTRL, 32'h00000001);
    `CHK("woken", 1'b0, halted)
    apb(1, mcu_exec_pkg::OFS_CMD, 32'h0E000000);
    apb(0, mcu_exec_pkg::OFS_STATUS, '0);
    `CHK("busy_two", 1'b1, rd[mcu_exec_pkg::STAT_BUSY])
    apb(1, mcu_exec_pkg::OFS_CMD, 32'h0E000000);
    `CHK("busy_refuse", 1'b1, er)
    repeat (8) @(posedge pclk);
    apb(1, mcu_exec_pkg::OFS_CMD, 32'h00000000);
    apb(0, mcu_exec_pkg::OFS_STATUS, '0);
    apb(1, mcu_exec_pkg::OFS_CMD, 32'h00000000);
    `CHK("one_cycle", 1'b0, er)
    apb(0, 8'h40, '0);
    `CHK("unmapped", 33'h100000000, {er, rd})
    tally_and_finish();
  end
endmodule
